/* core/msj_regs.svh */
// register offsets, field positions, reset values and timing for the
// multi-step speed and jog selector; assumes a 32-bit AXI4-Lite slave
`ifndef MSJ_REGS_SVH
`define MSJ_REGS_SVH

// byte offsets of the register words
`define MSJ_CTRL_OFS 8'h00
`define MSJ_STATUS_OFS 8'h04
`define MSJ_SETTLE_OFS 8'h08
`define MSJ_JOGF_OFS 8'h0C
`define MSJ_JOGSTOP_OFS 8'h10
`define MSJ_STARTF_OFS 8'h14
`define MSJ_OPERF_OFS 8'h18
`define MSJ_FUNCLO_OFS 8'h1C
`define MSJ_FUNCHI_OFS 8'h20
`define MSJ_FOUT_OFS 8'h24
`define MSJ_SPEED_OFS 8'h40
`define MSJ_SPEED_MASK 8'hC0

// control word fields
`define MSJ_CTRL_MODE_BIT 0
`define MSJ_CTRL_TERM_BIT 1
`define MSJ_CTRL_OPER_BIT 2

// reset values and limits (frequencies in 0.01 Hz)
`define MSJ_JOGF_RST 16'h0258
`define MSJ_JOGF_MAX 16'h03E7
`define MSJ_JOGSTOP_RST 3'h4
`define MSJ_JOGSTOP_MAX 3'h5
`define MSJ_SPEED0_RST 16'h0258
`define MSJ_STARTF_RST 16'h0032
`define MSJ_SETTLE_RST 8'h00

// input function codes
`define MSJ_FN_BIN_LO 8'h02
`define MSJ_FN_BIN_HI 8'h05
`define MSJ_FN_JOG 8'h06
`define MSJ_FN_PRIO_LO 8'h20
`define MSJ_FN_PRIO_HI 8'h26

// jog stop code fields
`define MSJ_JS_RUN_OK 3'h3

// timing: settle time counts in milliseconds
`define MSJ_MS_NS 1000000
`define MSJ_CLK_NS 40
`define MSJ_CYC_PER_MS (`MSJ_MS_NS / `MSJ_CLK_NS)

// AXI responses
`define MSJ_RESP_OKAY 2'h0
`define MSJ_RESP_SLVERR 2'h2

`endif

/* core/msj_pkg.sv */
// types of the multi-step speed and jog selector
// assumes the constants of msj_regs.svh alongside
package msj_pkg;

    // jog sequencer states, one-hot
    typedef enum logic [4:0] {
        MSJ_IDLE = 5'h01,
        MSJ_ARMED = 5'h02,
        MSJ_JOGGING = 5'h04,
        MSJ_NORMAL = 5'h08,
        MSJ_STOPPING = 5'h10
    } msj_state_t;

    // stop method applied when jogging ends
    typedef enum logic [1:0] {
        MSJ_STOP_NONE = 2'h0,
        MSJ_STOP_COAST = 2'h1,
        MSJ_STOP_DECEL = 2'h2,
        MSJ_STOP_DCBRAKE = 2'h3
    } msj_stop_t;

endpackage

/* core/msj_speed_select.sv */
// multi-step speed and jog selector: picks the frequency command from
// the terminals; assumes terminal pins are asynchronous and that the
// analog reference comes from logic on aclk
`timescale 1ns/1ps
`include "msj_regs.svh"

module msj_speed_select #(
    parameter int CYC_PER_MS = `MSJ_CYC_PER_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] term_in,
    input wire logic forward_run_cmd,
    input wire logic reverse_run_cmd,
    input wire logic [15:0] analog_ref,
    output logic [15:0] freq_cmd,
    output logic run_fwd,
    output logic run_rev,
    output logic jog_active,
    output logic coast_stop,
    output logic decel_stop,
    output logic dc_brake_stop
);

    // configuration registers
    logic [2:0] ctrl_r;
    logic [7:0] settle_ms_r;
    logic [15:0] jog_frequency_r;
    logic [2:0] jog_stop_method_r;
    logic [15:0] start_freq_r;
    logic [15:0] operator_freq_setting_r;
    logic [7:0] in_func_r [8];
    logic [15:0] speed_r [16];

    // pin synchronisers: ten pins, three flops each
    logic [9:0] pin_raw;
    logic [9:0] s1_r, s2_r, s3_r, pin_r;
    assign pin_raw = {reverse_run_cmd, forward_run_cmd, term_in};

    // a change counts only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 10'h000;
            s2_r <= 10'h000;
            s3_r <= 10'h000;
            pin_r <= 10'h000;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
        end
    end

    // terminal function decode per input
    logic [3:0] bin_part [8];
    logic [6:0] prio_part [8];
    logic [7:0] jog_part;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_fn
            wire logic [7:0] fc = in_func_r[gi];
            wire logic is_bin = fc >= `MSJ_FN_BIN_LO && fc <= `MSJ_FN_BIN_HI;
            wire logic is_prio = fc >= `MSJ_FN_PRIO_LO
                && fc <= `MSJ_FN_PRIO_HI;
            wire logic [7:0] bofs = fc - `MSJ_FN_BIN_LO;
            wire logic [7:0] pofs = fc - `MSJ_FN_PRIO_LO;
            assign bin_part[gi] = (is_bin && pin_r[gi])
                ? 4'h1 << bofs[1:0] : 4'h0;
            assign prio_part[gi] = (is_prio && pin_r[gi])
                ? 7'h01 << pofs[2:0] : 7'h00;
            assign jog_part[gi] = fc == `MSJ_FN_JOG && pin_r[gi];
        end
    endgenerate

    // gather the lines; bit 0 is the first select line
    logic [3:0] bin_sel_raw;
    logic [6:0] prio_sel_raw;
    always_comb begin
        bin_sel_raw = 4'h0;
        prio_sel_raw = 7'h00;
        for (int k = 0; k < 8; k++) begin
            bin_sel_raw = bin_sel_raw | bin_part[k];
            prio_sel_raw = prio_sel_raw | prio_part[k];
        end
    end

    wire logic jog_request = |jog_part;
    wire logic fwd_in = pin_r[8];
    wire logic rev_in = pin_r[9];
    wire logic run_in = fwd_in | rev_in;

    // binary settle: a millisecond prescaler and a stability counter
    logic [3:0] bin_cand_r, bin_code_r;
    logic [15:0] ms_div_r;
    logic [7:0] ms_cnt_r;
    wire logic bin_moved = bin_sel_raw != bin_cand_r;
    wire logic ms_tick = ms_div_r == 16'(CYC_PER_MS - 1);
    wire logic settled = ms_cnt_r >= settle_ms_r;

    // any movement restarts the wait, so transients shorter than the settle time never apply
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bin_cand_r <= 4'h0;
            bin_code_r <= 4'h0;
            ms_div_r <= 16'h0000;
            ms_cnt_r <= 8'h00;
        end else begin
            bin_cand_r <= bin_sel_raw;
            ms_div_r <= (bin_moved || ms_tick) ? 16'h0000 : ms_div_r + 16'h1;
            if (bin_moved)
                ms_cnt_r <= 8'h00;
            else if (ms_tick && !settled)
                ms_cnt_r <= ms_cnt_r + 8'h01;
            if (!bin_moved && settled)
                bin_code_r <= bin_cand_r;
        end
    end

    // priority encoder: lowest numbered active line wins
    logic [2:0] prio_idx;
    always_comb begin
        prio_idx = 3'h0;
        for (int k = 6; k >= 0; k--) begin
            if (prio_sel_raw[k])
                prio_idx = 3'(k + 1);
        end
    end

    // speed index and frequency selection
    wire logic bit_mode = ctrl_r[`MSJ_CTRL_MODE_BIT];
    wire logic [3:0] speed_idx = bit_mode ? {1'b0, prio_idx}
        : bin_code_r;
    wire logic [15:0] speed0_freq = ctrl_r[`MSJ_CTRL_TERM_BIT] ? analog_ref
        : ctrl_r[`MSJ_CTRL_OPER_BIT] ? operator_freq_setting_r
        : speed_r[0];
    wire logic [15:0] step_freq = speed_idx == 4'h0 ? speed0_freq
        : speed_r[speed_idx];

    // jog sequencer
    msj_pkg::msj_state_t state_r, state_nxt;
    msj_pkg::msj_stop_t stop_r, stop_nxt, coded_stop;
    wire logic jog_in_run = jog_stop_method_r >= `MSJ_JS_RUN_OK;
    // map jog stop code to its stop method
    always_comb begin
        unique case (jog_stop_method_r)
            3'h0, 3'h3: coded_stop = msj_pkg::MSJ_STOP_COAST;
            3'h1, 3'h4: coded_stop = msj_pkg::MSJ_STOP_DECEL;
            default: coded_stop = msj_pkg::MSJ_STOP_DCBRAKE;
        endcase
    end

    // for codes 00..02 the order of jog and run decides whether jogging happens
    always_comb begin
        state_nxt = state_r;
        stop_nxt = stop_r;
        unique case (state_r)
            msj_pkg::MSJ_IDLE: begin
                stop_nxt = msj_pkg::MSJ_STOP_NONE;
                if (jog_request && run_in)
                    state_nxt = msj_pkg::MSJ_JOGGING;
                else if (jog_request)
                    state_nxt = msj_pkg::MSJ_ARMED;
                else if (run_in)
                    state_nxt = msj_pkg::MSJ_NORMAL;
            end
            msj_pkg::MSJ_ARMED: begin
                if (!jog_request)
                    state_nxt = msj_pkg::MSJ_IDLE;
                else if (run_in)
                    state_nxt = msj_pkg::MSJ_JOGGING;
            end
            msj_pkg::MSJ_JOGGING: begin
                if (!run_in) begin
                    state_nxt = msj_pkg::MSJ_STOPPING;
                    stop_nxt = coded_stop;
                end else if (!jog_request) begin
                    state_nxt = msj_pkg::MSJ_STOPPING;
                    stop_nxt = msj_pkg::MSJ_STOP_COAST;
                end
            end
            msj_pkg::MSJ_NORMAL: begin
                if (!run_in)
                    state_nxt = msj_pkg::MSJ_IDLE;
                else if (jog_request && jog_in_run)
                    state_nxt = msj_pkg::MSJ_JOGGING;
                // codes 00..02 keep normal running here
            end
            msj_pkg::MSJ_STOPPING: begin
                if (!run_in && !jog_request)
                    state_nxt = msj_pkg::MSJ_IDLE;
            end
            default: begin
                state_nxt = msj_pkg::MSJ_IDLE;
                stop_nxt = msj_pkg::MSJ_STOP_NONE;
            end
        endcase
    end

    wire logic jogging_nxt = state_nxt == msj_pkg::MSJ_JOGGING;
    wire logic running_nxt = jogging_nxt
        || state_nxt == msj_pkg::MSJ_NORMAL;

    // state and registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= msj_pkg::MSJ_IDLE;
            stop_r <= msj_pkg::MSJ_STOP_NONE;
            freq_cmd <= 16'h0000;
            run_fwd <= 1'b0;
            run_rev <= 1'b0;
            jog_active <= 1'b0;
        end else begin
            state_r <= state_nxt;
            stop_r <= stop_nxt;
            freq_cmd <= jogging_nxt ? jog_frequency_r : step_freq;
            run_fwd <= running_nxt && fwd_in;
            run_rev <= running_nxt && rev_in && !fwd_in;
            jog_active <= jogging_nxt;
        end
    end

    // stop method outputs, held until jog and run are both off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coast_stop <= 1'b0;
            decel_stop <= 1'b0;
            dc_brake_stop <= 1'b0;
        end else begin
            coast_stop <= stop_nxt == msj_pkg::MSJ_STOP_COAST;
            decel_stop <= stop_nxt == msj_pkg::MSJ_STOP_DECEL;
            dc_brake_stop <= stop_nxt == msj_pkg::MSJ_STOP_DCBRAKE;
        end
    end

    // AXI4-Lite: address and data taken in either order
    logic aw_got_r, w_got_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    wire logic aw_take = awvalid && awready;
    wire logic w_take = wvalid && wready;
    wire logic b_done = bvalid && bready;
    wire logic do_write = aw_got_r && w_got_r && !bvalid;
    wire logic aw_got_nxt = (aw_got_r || aw_take) && !b_done;
    wire logic w_got_nxt = (w_got_r || w_take) && !b_done;

    // register read mux, also the old value for strobe merging
    function automatic logic [32:0] reg_read(input logic [7:0] a);
        logic [32:0] v;
        v = {1'b1, 32'h0};
        if ((a & `MSJ_SPEED_MASK) == `MSJ_SPEED_OFS)
            v[15:0] = speed_r[a[5:2]];
        else if (a == `MSJ_CTRL_OFS)
            v[2:0] = ctrl_r;
        else if (a == `MSJ_STATUS_OFS)
            v[15:0] = {coast_stop, decel_stop, dc_brake_stop, jog_active,
                3'h0, state_r, speed_idx};
        else if (a == `MSJ_SETTLE_OFS)
            v[7:0] = settle_ms_r;
        else if (a == `MSJ_JOGF_OFS)
            v[15:0] = jog_frequency_r;
        else if (a == `MSJ_JOGSTOP_OFS)
            v[2:0] = jog_stop_method_r;
        else if (a == `MSJ_STARTF_OFS)
            v[15:0] = start_freq_r;
        else if (a == `MSJ_OPERF_OFS)
            v[15:0] = operator_freq_setting_r;
        else if (a == `MSJ_FUNCLO_OFS)
            v[31:0] = {in_func_r[3], in_func_r[2], in_func_r[1], in_func_r[0]};
        else if (a == `MSJ_FUNCHI_OFS)
            v[31:0] = {in_func_r[7], in_func_r[6], in_func_r[5], in_func_r[4]};
        else if (a == `MSJ_FOUT_OFS)
            v[15:0] = freq_cmd;
        else
            v[32] = 1'b0;
        return v;
    endfunction

    // process form, so a register change re-runs the mux
    logic [32:0] wr_old;
    always_comb wr_old = reg_read(aw_addr_r);
    wire logic [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
        {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire logic [31:0] wv = (wr_old[31:0] & ~strb_mask)
        | (w_data_r & strb_mask);
    wire logic jogf_ok = wv[15:0] == 16'h0000
        || (wv[15:0] >= start_freq_r && wv[15:0] <= `MSJ_JOGF_MAX);
    wire logic is_spd = (aw_addr_r & `MSJ_SPEED_MASK) == `MSJ_SPEED_OFS;

    // write channel handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `MSJ_RESP_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awready <= !aw_got_nxt;
            wready <= !w_got_nxt;
            if (aw_take)
                aw_addr_r <= {awaddr[7:2], 2'b00};
            if (w_take) begin
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_old[32] ? `MSJ_RESP_OKAY : `MSJ_RESP_SLVERR;
            end else if (b_done) begin
                bvalid <= 1'b0;
            end
        end
    end

    // register writes; out-of-range settings keep the old value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= 3'h0;
            settle_ms_r <= `MSJ_SETTLE_RST;
            jog_frequency_r <= `MSJ_JOGF_RST;
            jog_stop_method_r <= `MSJ_JOGSTOP_RST;
            start_freq_r <= `MSJ_STARTF_RST;
            operator_freq_setting_r <= 16'h0000;
            for (int k = 0; k < 8; k++)
                in_func_r[k] <= 8'h00;
            for (int k = 0; k < 16; k++)
                speed_r[k] <= k == 0 ? `MSJ_SPEED0_RST : 16'h0000;
        end else if (do_write) begin
            if (is_spd)
                speed_r[aw_addr_r[5:2]] <= wv[15:0];
            else if (aw_addr_r == `MSJ_CTRL_OFS)
                ctrl_r <= wv[2:0];
            else if (aw_addr_r == `MSJ_SETTLE_OFS)
                settle_ms_r <= wv[7:0];
            else if (aw_addr_r == `MSJ_JOGF_OFS && jogf_ok)
                jog_frequency_r <= wv[15:0];
            else if (aw_addr_r == `MSJ_JOGSTOP_OFS
                    && wv[2:0] <= `MSJ_JOGSTOP_MAX && wv[31:3] == 29'h0)
                jog_stop_method_r <= wv[2:0];
            else if (aw_addr_r == `MSJ_STARTF_OFS)
                start_freq_r <= wv[15:0];
            else if (aw_addr_r == `MSJ_OPERF_OFS)
                operator_freq_setting_r <= wv[15:0];
            else if (aw_addr_r == `MSJ_FUNCLO_OFS)
                for (int k = 0; k < 4; k++)
                    in_func_r[k] <= wv[8*k +: 8];
            else if (aw_addr_r == `MSJ_FUNCHI_OFS)
                for (int k = 0; k < 4; k++)
                    in_func_r[k + 4] <= wv[8*k +: 8];
        end
    end

    // read channel; one read outstanding
    wire logic ar_take = arvalid && arready;
    logic [32:0] rd_val;
    always_comb rd_val = reg_read({araddr[7:2], 2'b00});
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `MSJ_RESP_OKAY;
        end else if (ar_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val[31:0];
            rresp <= rd_val[32] ? `MSJ_RESP_OKAY : `MSJ_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

endmodule

/* bench/msj_monitor.sv */
// port checker for the speed and jog selector, bound to each instance
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module msj_monitor #(
    parameter int CYC_PER_MS = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [15:0] freq_cmd,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic jog_active,
    input wire logic coast_stop,
    input wire logic decel_stop,
    input wire logic dc_brake_stop
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // both write halves taken at one edge, then the answer
    sequence s_both_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_answer_held;
        bvalid && !awready && !wready;
    endsequence

    a_write_answer: assert property (s_both_taken |=> ##1 s_answer_held)
        else $error("write response late");
    a_resp_hold: assert property (bvalid && !bready
        |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read response late");
    a_read_hold: assert property (rvalid && !rready
        |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_jog_runs: assert property (jog_active |-> run_fwd || run_rev)
        else $error("jogging without running");
    a_jog_limit: assert property (jog_active |-> freq_cmd <= 16'h03E7)
        else $error("jog frequency above limit");
    a_one_stop: assert property
        ($onehot0({coast_stop, decel_stop, dc_brake_stop}))
        else $error("several stop methods at once");
    a_stop_ends_jog: assert property
        ((coast_stop || decel_stop || dc_brake_stop) |-> !jog_active)
        else $error("stop method while jogging");
endmodule

bind msj_speed_select msj_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready), .freq_cmd(freq_cmd),
    .run_fwd(run_fwd), .run_rev(run_rev), .jog_active(jog_active),
    .coast_stop(coast_stop), .decel_stop(decel_stop),
    .dc_brake_stop(dc_brake_stop)
);

/* bench/msj_term_model.sv */
// switches or controller on the terminal side of the selector
// assumes the bench calls its tasks; levels change after a rising edge
`timescale 1ns/1ps
module msj_term_model (
    input wire logic aclk,
    output logic [7:0] term_in,
    output logic forward_run_cmd,
    output logic reverse_run_cmd
);
    // switches idle open
    initial begin
        term_in = 8'h00;
        forward_run_cmd = 1'b0;
        reverse_run_cmd = 1'b0;
    end

    // jog sits on whichever input the bench gave code 06
    task automatic set_terms(input logic [7:0] v);
        @(posedge aclk);
        term_in <= v;
    endtask

    // jog goes first unless a scenario breaks the order on purpose
    task automatic set_run(input logic f);
        @(posedge aclk);
        forward_run_cmd <= f;
    endtask

    task automatic set_rev(input logic r);
        @(posedge aclk);
        reverse_run_cmd <= r;
    endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the speed and jog selector
// assumes msj_regs.svh on the include path and the terminal model
`timescale 1ns/1ps
`include "msj_regs.svh"
module tb;
    localparam int CPM = 10;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, term_in;
    logic [3:0] wstrb = 4'hF, strb_sel = 4'hF;
    logic [2:0] awprot = 3'h2, arprot = 3'h1;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic forward_run_cmd, reverse_run_cmd, run_fwd, run_rev, jog_active;
    logic [15:0] analog_ref, freq_cmd;
    logic coast_stop, decel_stop, dc_brake_stop;
    int n_mismatch = 0;
    int check_count = 0;

    msj_speed_select #(.CYC_PER_MS(CPM)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .term_in(term_in), .forward_run_cmd(forward_run_cmd),
        .reverse_run_cmd(reverse_run_cmd), .analog_ref(analog_ref),
        .freq_cmd(freq_cmd), .run_fwd(run_fwd), .run_rev(run_rev),
        .jog_active(jog_active), .coast_stop(coast_stop),
        .decel_stop(decel_stop), .dc_brake_stop(dc_brake_stop)
    );
    msj_term_model partner_u (
        .aclk(aclk), .term_in(term_in), .forward_run_cmd(forward_run_cmd),
        .reverse_run_cmd(reverse_run_cmd)
    );

    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // both write halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb_sel;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        chk(34'(bresp), 34'(er));
    endtask

    // rready held from the start, data taken at the handshake edge
    task automatic rd(input logic [7:0] a, output logic [33:0] rv);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rv = {rresp, rdata};
        rready <= 1'b0;
    endtask

    // pin filter plus one ms settle at CPM cycles, with margin
    task automatic hold_on;
        repeat (30) @(posedge aclk);
    endtask

    task automatic t_regs;
        logic [33:0] v;
        rd(`MSJ_JOGF_OFS, v);
        chk(v, 34'h258);
        rd(`MSJ_JOGSTOP_OFS, v);
        chk(v, 34'h4);
        rd(8'h3C, v);
        chk(v, 34'h200000000);
        wr(8'h3C, 32'h1, `MSJ_RESP_SLVERR);
        wr(`MSJ_JOGF_OFS, 32'h3E8, `MSJ_RESP_OKAY);
        wr(`MSJ_JOGF_OFS, 32'h31, `MSJ_RESP_OKAY);
        rd(`MSJ_JOGF_OFS, v);
        chk(v, 34'h258);
        wr(`MSJ_JOGF_OFS, 32'h0, `MSJ_RESP_OKAY);
        rd(`MSJ_JOGF_OFS, v);
        chk(v, 34'h0);
        wr(`MSJ_JOGSTOP_OFS, 32'h6, `MSJ_RESP_OKAY);
        rd(`MSJ_JOGSTOP_OFS, v);
        chk(v, 34'h4);
        // only byte lane 1 may land
        strb_sel = 4'h2;
        wr(`MSJ_OPERF_OFS, 32'hCDAB, `MSJ_RESP_OKAY);
        strb_sel = 4'hF;
        rd(`MSJ_OPERF_OFS, v);
        chk(v, 34'hCD00);
    endtask

    task automatic t_binary;
        wr(`MSJ_FUNCLO_OFS, 32'h05040302, `MSJ_RESP_OKAY);
        wr(`MSJ_FUNCHI_OFS, 32'h06000000, `MSJ_RESP_OKAY);
        wr(`MSJ_SETTLE_OFS, 32'h1, `MSJ_RESP_OKAY);
        for (int n = 1; n < 16; n++)
            wr(8'(`MSJ_SPEED_OFS + 4 * n), 32'h100 + n, `MSJ_RESP_OKAY);
        partner_u.set_run(1'b1);
        for (int n = 0; n < 16; n++) begin
            partner_u.set_terms(8'(n));
            hold_on;
            chk(34'(freq_cmd), n == 0 ? 34'h258 : 34'(32'h100 + n));
        end
        // a short-lived code must never reach the output
        partner_u.set_terms(8'h05);
        repeat (6) @(posedge aclk);
        partner_u.set_terms(8'h0F);
        repeat (2) @(posedge aclk);
        chk(34'(freq_cmd), 34'h10F);
        analog_ref <= 16'h1234;
        partner_u.set_terms(8'h00);
        wr(`MSJ_CTRL_OFS, 32'h2, `MSJ_RESP_OKAY);
        hold_on;
        chk(34'(freq_cmd), 34'h1234);
        wr(`MSJ_OPERF_OFS, 32'h777, `MSJ_RESP_OKAY);
        wr(`MSJ_CTRL_OFS, 32'h4, `MSJ_RESP_OKAY);
        hold_on;
        chk(34'(freq_cmd), 34'h777);
        partner_u.set_run(1'b0);
        hold_on;
    endtask

    task automatic t_prio;
        wr(`MSJ_CTRL_OFS, 32'h1, `MSJ_RESP_OKAY);
        wr(`MSJ_FUNCLO_OFS, 32'h23222120, `MSJ_RESP_OKAY);
        wr(`MSJ_FUNCHI_OFS, 32'h06262524, `MSJ_RESP_OKAY);
        partner_u.set_run(1'b1);
        // every line from k upward on: line k must win
        for (int k = 1; k < 8; k++) begin
            partner_u.set_terms(8'((8'h7F << (k - 1)) & 8'h7F));
            hold_on;
            chk(34'(freq_cmd), 34'(32'h100 + k));
        end
        partner_u.set_terms(8'h00);
        hold_on;
        chk(34'(freq_cmd), 34'h258);
        partner_u.set_run(1'b0);
        partner_u.set_rev(1'b1);
        hold_on;
        chk(34'({run_fwd, run_rev}), 34'h1);
        partner_u.set_rev(1'b0);
        hold_on;
    endtask

    task automatic t_jog(input int code, input logic run_first);
        logic [2:0] stp;
        logic jog_ok;
        stp = (code % 3 == 0) ? 3'h4 : (code % 3 == 1) ? 3'h2 : 3'h1;
        jog_ok = !run_first || code >= 3;
        wr(`MSJ_JOGSTOP_OFS, 32'(code), `MSJ_RESP_OKAY);
        if (run_first) begin
            partner_u.set_run(1'b1);
            hold_on;
        end
        partner_u.set_terms(8'h80);
        hold_on;
        if (!run_first) begin
            partner_u.set_run(1'b1);
            hold_on;
        end
        chk(34'(jog_active), 34'(jog_ok));
        if (jog_ok)
            chk(34'(freq_cmd), 34'h190);
        if (run_first && code >= 3) begin
            partner_u.set_terms(8'h00);
            hold_on;
            chk(34'({coast_stop, decel_stop, dc_brake_stop}), 34'h4);
        end
        partner_u.set_run(1'b0);
        hold_on;
        if (!run_first)
            chk(34'({coast_stop, decel_stop, dc_brake_stop}), 34'(stp));
        partner_u.set_terms(8'h00);
        hold_on;
        chk(34'({coast_stop, decel_stop, dc_brake_stop}), 34'h0);
    endtask

    // main sequence: reset, registers, both step modes, every jog code
    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        analog_ref = 16'h0000;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_binary;
        t_prio;
        wr(`MSJ_JOGF_OFS, 32'h190, `MSJ_RESP_OKAY);
        for (int c = 0; c < 6; c++)
            t_jog(c, 1'b0);
        t_jog(1, 1'b1);
        t_jog(3, 1'b1);
        close_out;
    end

    // hang guard, well beyond the few thousand cycles of the run
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        close_out;
    end
endmodule
